// ===== gex_chk.sv
// gex_chk.sv: port assertions for the gpio expander front end.
// assumes: bound to gex_top; bus pins resolved outside the block.
`timescale 1ns/1ps
`default_nettype none
module gex_chk (
    // clock and reset
    input wire logic       CLK_SYS,
    input wire logic       NRST,
    // serial bus and interrupt
    input wire logic       SCL,
    input wire logic       SDA_O,
    input wire logic       SDA_OE,
    input wire logic       INT_O,
    input wire logic       INT_OE,
    // pad controls
    input wire logic [7:0] BANK0_PIN_OE,
    input wire logic [7:0] BANK0_HOLD_EN,
    input wire logic [7:0] BANK0_PULL_EN,
    input wire logic [7:0] BANK1_PIN_OE,
    input wire logic [7:0] BANK1_HOLD_EN,
    input wire logic [7:0] BANK1_PULL_EN
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);
    // open-drain pins may only ever pull low
    sda_od_a: assert property (SDA_OE |-> !SDA_O)
        else $error("sda driven high");
    int_od_a: assert property (INT_OE |-> !INT_O)
        else $error("int driven high");
    // keeper and pull never fight; keeper only on undriven pins
    pull_hold_a: assert property ((BANK0_PULL_EN & BANK0_HOLD_EN) == 8'h00
        && (BANK1_PULL_EN & BANK1_HOLD_EN) == 8'h00)
        else $error("pull and keeper both on");
    keep_input_a: assert property ((BANK0_PIN_OE & BANK0_HOLD_EN) == 8'h00
        && (BANK1_PIN_OE & BANK1_HOLD_EN) == 8'h00)
        else $error("keeper on a driven pin");
    // reset must win even in its own cycles, so no disable here
    reset_idle_a: assert property (disable iff (1'b0) !NRST |=> !SDA_OE
        && !INT_OE && BANK0_PIN_OE == 8'h00 && BANK1_PULL_EN == 8'hff)
        else $error("state not cleared by reset");
    // acknowledge starts while scl is low and spans its high phase
    ack_low_a: assert property ($rose(SDA_OE) |-> !SCL)
        else $error("sda pulled while scl high");
    ack_hold_a: assert property ($rose(SDA_OE) |-> SDA_OE [*8])
        else $error("sda pull too short");
    sda_quiet_a: assert property (SCL && $past(SCL) |-> $stable(SDA_OE))
        else $error("sda moved while scl high");
endmodule : gex_chk
bind gex_top gex_chk u_chk (.CLK_SYS(CLK_SYS), .NRST(NRST), .SCL(SCL),
    .SDA_O(SDA_O), .SDA_OE(SDA_OE), .INT_O(INT_O), .INT_OE(INT_OE),
    .BANK0_PIN_OE(BANK0_PIN_OE), .BANK0_HOLD_EN(BANK0_HOLD_EN),
    .BANK0_PULL_EN(BANK0_PULL_EN), .BANK1_PIN_OE(BANK1_PIN_OE),
    .BANK1_HOLD_EN(BANK1_HOLD_EN), .BANK1_PULL_EN(BANK1_PULL_EN));
`default_nettype wire

// ===== gex_ctl.sv
// gex_ctl.sv: behavioural bus controller facing the expander.
// assumes: sda is the resolved wire level with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module gex_ctl (
    // pacing clock
    input  wire logic clk,
    // bus lines
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda
);
    // idle: scl stands high, sda released
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // set both lines just after an edge, then hold n cycles
    task automatic step(input logic c, input logic d, input int n);
        scl = c;
        sda_low = d;
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    // data moves only a quarter after scl falls, never near a rise
    task automatic bit_io(input logic b, output logic r);
        step(1'b0, sda_low, 4);
        step(1'b0, ~b, 4);
        step(1'b1, ~b, 8);
        r = sda;
    endtask : bit_io
    // start or repeated start: sda falls while scl high
    task automatic start;
        step(1'b0, sda_low, 4);
        step(1'b0, 1'b0, 4);
        step(1'b1, 1'b0, 8);
        step(1'b1, 1'b1, 8);
    endtask : start
    // stop: sda rises while scl high
    task automatic stop;
        step(1'b0, sda_low, 4);
        step(1'b0, 1'b1, 4);
        step(1'b1, 1'b1, 8);
        step(1'b1, 1'b0, 8);
    endtask : stop
    // byte out msb first, ninth bit returns the acknowledge
    task automatic tx(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask : tx
    // byte in msb first, then our acknowledge or not
    task automatic rx(output logic [7:0] b, input logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
        bit_io(~ack, r);
    endtask : rx
endmodule : gex_ctl
`default_nettype wire

// ===== gex_defs.svh
// gex_defs.svh: constants of the gpio expander target front end.
// assumes: included by bare name from the package and the top module.
`ifndef GEX_DEFS_SVH
`define GEX_DEFS_SVH

// register groups, taken from command index bits [3:1]
`define GEX_GRP_INPUT    3'h0
`define GEX_GRP_INVERT   3'h1
`define GEX_GRP_HOLD     3'h2
`define GEX_GRP_PULL     3'h3
`define GEX_GRP_DIR      3'h4
`define GEX_GRP_OUT      3'h5
`define GEX_GRP_MASK     3'h6
`define GEX_GRP_STATUS   3'h7

// command pointer layout and reset value
`define GEX_CMD_RST      8'h00
`define GEX_CMD_AI_BIT   7
`define GEX_CMD_RSV_HI   6
`define GEX_CMD_RSV_LO   4
`define GEX_CMD_RSV_OK   3'h0

// per-bank reset values; direction 1 = input
`define GEX_INVERT_RST   8'h00
`define GEX_HOLD_RST     8'h00
`define GEX_PULL_RST     8'h00
`define GEX_DIR_RST      8'hff
`define GEX_OUT_RST      8'h00
`define GEX_MASK_RST     8'hff
`define GEX_STATUS_RST   8'h00

// serial byte framing
`define GEX_BYTE_BITS    4'h8
`define GEX_LAST_TX_BIT  4'h7

`endif

// ===== gex_pkg.sv
// gex_pkg.sv: types shared by the expander front end.
// assumes: nothing beyond the constants header.
`include "gex_defs.svh"

package gex_pkg;

    // serial engine states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_CMD,
        ST_WDATA,
        ST_ACK,
        ST_RDATA,
        ST_RACK
    } gex_state_t;

    typedef logic [7:0] gex_byte_t;

endpackage : gex_pkg

// ===== gex_sync.sv
// gex_sync.sv: three-flop input synchroniser with agreement filter.
// assumes: d comes from outside the CLK_SYS domain.
`timescale 1ns/1ps
`default_nettype none

module gex_sync #(
    parameter int              WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // asynchronous input and filtered result
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;

    // s1 feeds s2 only; a level counts once s2 and s3 agree
    // chain keeps sampling in reset so q leaves it at the real level
    // and no false edge follows release; needs reset >= 4 clocks
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            q  <= s3;
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            q  <= (s2 & s3) | (q & (s2 ^ s3)); // hold on disagreement
        end
    end

endmodule : gex_sync
`default_nettype wire

// ===== gex_top.sv
// gex_top.sv: i2c target front end and two 8-pin gpio banks.
// assumes: SCL, SDA and pins are oversampled by CLK_SYS (100 MHz) with
// the bus clock far slower; pads resolve open-drain and pull levels.
`timescale 1ns/1ps
`default_nettype none
`include "gex_defs.svh"

module gex_top #(
    parameter bit        VARIANT_28PIN = 1'b0,
    parameter logic [6:0] FIXED_ADDR   = 7'h20,
    parameter logic [2:0] ADDR_HI      = 3'h2,
    parameter int        BANK_PINS     = 8
) (
    // clock and reset
    input  wire logic       CLK_SYS,
    input  wire logic       NRST,
    // serial bus
    input  wire logic       SCL,
    input  wire logic       SDA_I,
    output logic            SDA_O,
    output logic            SDA_OE,
    // address select pins
    input  wire logic       ADDR_SELECT_PIN_0,
    input  wire logic       ADDR_SELECT_PIN_1,
    input  wire logic       ADDR_SELECT_PIN_2,
    input  wire logic       ADDR_SELECT_PIN_3,
    // bank 0 pads
    input  wire logic [7:0] BANK0_PIN_I,
    output logic      [7:0] BANK0_PIN_O,
    output logic      [7:0] BANK0_PIN_OE,
    output logic      [7:0] BANK0_HOLD_EN,
    output logic      [7:0] BANK0_HOLD_VAL,
    output logic      [7:0] BANK0_PULL_EN,
    output logic      [7:0] BANK0_PULL_UP,
    // bank 1 pads
    input  wire logic [7:0] BANK1_PIN_I,
    output logic      [7:0] BANK1_PIN_O,
    output logic      [7:0] BANK1_PIN_OE,
    output logic      [7:0] BANK1_HOLD_EN,
    output logic      [7:0] BANK1_HOLD_VAL,
    output logic      [7:0] BANK1_PULL_EN,
    output logic      [7:0] BANK1_PULL_UP,
    // interrupt pad, open drain
    output logic            INT_O,
    output logic            INT_OE
);

    // byte-wide register logic cannot serve other bank widths
    if (BANK_PINS != 8) begin : g_bad_width
        $error("gex_top: BANK_PINS must be 8");
    end

    // synchronised inputs
    logic [21:0]                sync_q;
    logic                       scl_f;
    logic                       sda_f;
    logic [3:0]                 addr_pins;
    logic [7:0]                 pin_in [0:1];

    // edge detection state
    logic                       scl_q;
    logic                       sda_q;
    logic                       scl_rise;
    logic                       scl_fall;
    logic                       start_det;
    logic                       stop_det;

    // serial engine
    gex_pkg::gex_state_t        state;
    gex_pkg::gex_state_t        nxt_state;
    logic [3:0]                 bit_cnt;
    gex_pkg::gex_byte_t         rx_sh;
    gex_pkg::gex_byte_t         tx_sh;
    gex_pkg::gex_byte_t         command_pointer_reg;
    logic                       sda_oe_reg;
    gex_pkg::gex_byte_t         rd_cur;
    logic                       m_ack;
    logic [6:0]                 dev_addr;
    logic                       cmd_ok;

    // register access strobes
    logic                       wr_stb;
    logic [3:0]                 wr_idx;
    gex_pkg::gex_byte_t         wr_data;
    logic                       rd_stb;
    logic [3:0]                 rd_idx;

    // port registers, index 0 = bank 0
    logic [7:0]                 inv_reg    [0:1];
    logic [7:0]                 hold_reg   [0:1];
    logic [7:0]                 pull_reg   [0:1];
    logic [7:0]                 dir_reg    [0:1];
    logic [7:0]                 out_reg    [0:1];
    logic [7:0]                 mask_reg   [0:1];
    logic [7:0]                 status_reg [0:1];
    logic [7:0]                 in_prev    [0:1];
    logic [1:0]                 int_pend;

    // all off-domain inputs pass one filtered synchroniser
    gex_sync #(
        .WIDTH (22)
    ) u_sync (
        .clk   (CLK_SYS),
        .rst_n (NRST),
        .d     ({SCL, SDA_I, ADDR_SELECT_PIN_3, ADDR_SELECT_PIN_2,
                 ADDR_SELECT_PIN_1, ADDR_SELECT_PIN_0,
                 BANK1_PIN_I, BANK0_PIN_I}),
        .q     (sync_q)
    );

    // unpack synchronised inputs
    assign scl_f     = sync_q[21];
    assign sda_f     = sync_q[20];
    assign addr_pins = sync_q[19:16];
    assign pin_in[1] = sync_q[15:8];
    assign pin_in[0] = sync_q[7:0];

    // previous bus levels for edge and condition detection
    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_f;
            sda_q <= sda_f;
        end
    end

    // bus events; start and stop only while clock is high
    assign scl_rise  = scl_f & ~scl_q;
    assign scl_fall  = ~scl_f & scl_q;
    assign start_det = scl_f & scl_q & sda_q & ~sda_f;
    assign stop_det  = scl_f & scl_q & ~sda_q & sda_f;

    // target address: fixed, or upper bits plus four strap pins
    assign dev_addr = VARIANT_28PIN ? {ADDR_HI, addr_pins}
                                    : FIXED_ADDR;

    // only codes with zero reserved bits are accepted
    assign cmd_ok = (rx_sh[`GEX_CMD_RSV_HI:`GEX_CMD_RSV_LO]
                     == `GEX_CMD_RSV_OK);

    // pointer after one data byte; four-bit index wraps by itself
    function automatic gex_pkg::gex_byte_t ptr_next(
        input gex_pkg::gex_byte_t p
    );
        if (p[`GEX_CMD_AI_BIT]) begin
            ptr_next = {p[7:4], p[3:0] + 4'h1};
        end else begin
            ptr_next = p;
        end
    endfunction : ptr_next

    // read value of one indexed register
    function automatic gex_pkg::gex_byte_t rd_byte(input logic [3:0] idx);
        case (idx[3:1])
            `GEX_GRP_INPUT:  rd_byte = pin_in[idx[0]] ^ inv_reg[idx[0]];
            `GEX_GRP_INVERT: rd_byte = inv_reg[idx[0]];
            `GEX_GRP_HOLD:   rd_byte = hold_reg[idx[0]];
            `GEX_GRP_PULL:   rd_byte = pull_reg[idx[0]];
            `GEX_GRP_DIR:    rd_byte = dir_reg[idx[0]];
            `GEX_GRP_OUT:    rd_byte = out_reg[idx[0]];
            `GEX_GRP_MASK:   rd_byte = mask_reg[idx[0]];
            default:         rd_byte = status_reg[idx[0]];
        endcase
    endfunction : rd_byte

    // byte a read would load now; one copy keeps bit 7 and byte aligned
    always_comb begin
        rd_cur = rd_byte(command_pointer_reg[3:0]);
    end

    // serial engine: bits taken on scl rise, sda changed on scl fall
    always_ff @(posedge CLK_SYS) begin
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
        if (!NRST) begin
            state               <= gex_pkg::ST_IDLE;
            nxt_state           <= gex_pkg::ST_IDLE;
            bit_cnt             <= 4'h0;
            rx_sh               <= 8'h00;
            tx_sh               <= 8'h00;
            command_pointer_reg <= `GEX_CMD_RST;
            sda_oe_reg          <= 1'b0;
            m_ack               <= 1'b0;
            wr_idx              <= 4'h0;
            wr_data             <= 8'h00;
            rd_idx              <= 4'h0;
        end else if (start_det) begin
            // a repeated start keeps the pointer for the read phase
            state      <= gex_pkg::ST_ADDR;
            bit_cnt    <= 4'h0;
            sda_oe_reg <= 1'b0;
        end else if (stop_det) begin
            state      <= gex_pkg::ST_IDLE;
            sda_oe_reg <= 1'b0;
        end else begin
            case (state)
                gex_pkg::ST_ADDR,
                gex_pkg::ST_CMD,
                gex_pkg::ST_WDATA: begin
                    if (scl_rise && bit_cnt != `GEX_BYTE_BITS) begin
                        rx_sh   <= {rx_sh[6:0], sda_f};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == `GEX_BYTE_BITS) begin
                        bit_cnt <= 4'h0;
                        if (state == gex_pkg::ST_ADDR) begin
                            if (rx_sh[7:1] == dev_addr) begin
                                sda_oe_reg <= 1'b1;
                                state      <= gex_pkg::ST_ACK;
                                nxt_state  <= rx_sh[0] ? gex_pkg::ST_RDATA
                                                       : gex_pkg::ST_CMD;
                            end else begin
                                state <= gex_pkg::ST_IDLE;
                            end
                        end else if (state == gex_pkg::ST_CMD) begin
                            if (cmd_ok) begin
                                command_pointer_reg <= rx_sh;
                                sda_oe_reg          <= 1'b1;
                                state               <= gex_pkg::ST_ACK;
                                nxt_state           <= gex_pkg::ST_WDATA;
                            end else begin
                                state <= gex_pkg::ST_IDLE;
                            end
                        end else begin
                            // every data byte is acked, even to read-only
                            wr_stb              <= 1'b1;
                            wr_idx              <= command_pointer_reg[3:0];
                            wr_data             <= rx_sh;
                            command_pointer_reg <= ptr_next(command_pointer_reg);
                            sda_oe_reg          <= 1'b1;
                            state               <= gex_pkg::ST_ACK;
                            nxt_state           <= gex_pkg::ST_WDATA;
                        end
                    end
                end
                gex_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        state <= nxt_state;
                        if (nxt_state == gex_pkg::ST_RDATA) begin
                            tx_sh      <= rd_cur;
                            sda_oe_reg <= ~rd_cur[7];
                            rd_stb     <= 1'b1;
                            rd_idx     <= command_pointer_reg[3:0];
                        end else begin
                            sda_oe_reg <= 1'b0;
                        end
                    end
                end
                gex_pkg::ST_RDATA: begin
                    if (scl_fall) begin
                        if (bit_cnt == `GEX_LAST_TX_BIT) begin
                            bit_cnt             <= 4'h0;
                            sda_oe_reg          <= 1'b0;
                            command_pointer_reg <= ptr_next(command_pointer_reg);
                            m_ack               <= 1'b0;
                            state               <= gex_pkg::ST_RACK;
                        end else begin
                            tx_sh      <= {tx_sh[6:0], 1'b0};
                            sda_oe_reg <= ~tx_sh[6];
                            bit_cnt    <= bit_cnt + 4'h1;
                        end
                    end
                end
                gex_pkg::ST_RACK: begin
                    if (scl_rise) begin
                        m_ack <= ~sda_f;
                    end else if (scl_fall) begin
                        if (m_ack) begin
                            tx_sh      <= rd_cur;
                            sda_oe_reg <= ~rd_cur[7];
                            rd_stb     <= 1'b1;
                            rd_idx     <= command_pointer_reg[3:0];
                            state      <= gex_pkg::ST_RDATA;
                        end else begin
                            state <= gex_pkg::ST_IDLE; // released until stop
                        end
                    end
                end
                default: begin
                    sda_oe_reg <= 1'b0;
                end
            endcase
        end
    end

    // writable port registers; input and status groups drop writes
    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            for (int b = 0; b < 2; b++) begin
                inv_reg[b]  <= `GEX_INVERT_RST;
                hold_reg[b] <= `GEX_HOLD_RST;
                pull_reg[b] <= `GEX_PULL_RST;
                dir_reg[b]  <= `GEX_DIR_RST;
                out_reg[b]  <= `GEX_OUT_RST;
                mask_reg[b] <= `GEX_MASK_RST;
            end
        end else if (wr_stb) begin
            case (wr_idx[3:1])
                `GEX_GRP_INVERT: inv_reg[wr_idx[0]]  <= wr_data;
                `GEX_GRP_HOLD:   hold_reg[wr_idx[0]] <= wr_data;
                `GEX_GRP_PULL:   pull_reg[wr_idx[0]] <= wr_data;
                `GEX_GRP_DIR:    dir_reg[wr_idx[0]]  <= wr_data;
                `GEX_GRP_OUT:    out_reg[wr_idx[0]]  <= wr_data;
                `GEX_GRP_MASK:   mask_reg[wr_idx[0]] <= wr_data;
                default: begin
                    // read-only target: byte is discarded
                end
            endcase
        end
    end

    // change flags on input pins; a new change beats a read clear
    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            for (int b = 0; b < 2; b++) begin
                status_reg[b] <= `GEX_STATUS_RST;
                in_prev[b]    <= pin_in[b]; // no false change at release
            end
        end else begin
            for (int b = 0; b < 2; b++) begin
                in_prev[b] <= pin_in[b];
                if (rd_stb && rd_idx == {`GEX_GRP_STATUS, b[0]}) begin
                    // clear only what was just loaded for the reader
                    status_reg[b] <= (status_reg[b] & ~tx_sh)
                                   | ((pin_in[b] ^ in_prev[b]) & dir_reg[b]);
                end else begin
                    status_reg[b] <= status_reg[b]
                                   | ((pin_in[b] ^ in_prev[b]) & dir_reg[b]);
                end
            end
        end
    end

    // unmasked pending flags per bank
    assign int_pend[0] = |(status_reg[0] & ~mask_reg[0]);
    assign int_pend[1] = |(status_reg[1] & ~mask_reg[1]);

    // pad controls registered so every output comes from a flop
    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            SDA_O          <= 1'b0;
            SDA_OE         <= 1'b0;
            INT_O          <= 1'b0;
            INT_OE         <= 1'b0;
            BANK0_PIN_O    <= `GEX_OUT_RST;
            BANK0_PIN_OE   <= ~`GEX_DIR_RST;
            BANK0_HOLD_EN  <= 8'h00;
            BANK0_HOLD_VAL <= 8'h00;
            BANK0_PULL_EN  <= ~`GEX_HOLD_RST;
            BANK0_PULL_UP  <= `GEX_PULL_RST;
            BANK1_PIN_O    <= `GEX_OUT_RST;
            BANK1_PIN_OE   <= ~`GEX_DIR_RST;
            BANK1_HOLD_EN  <= 8'h00;
            BANK1_HOLD_VAL <= 8'h00;
            BANK1_PULL_EN  <= ~`GEX_HOLD_RST;
            BANK1_PULL_UP  <= `GEX_PULL_RST;
        end else begin
            // open drain: data low, enable carries the level
            SDA_O          <= 1'b0;
            SDA_OE         <= sda_oe_reg;
            INT_O          <= 1'b0;
            INT_OE         <= |int_pend;
            BANK0_PIN_O    <= out_reg[0];
            BANK0_PIN_OE   <= ~dir_reg[0];
            // keeper only on undriven inputs; it repeats the last level
            BANK0_HOLD_EN  <= hold_reg[0] & dir_reg[0];
            BANK0_HOLD_VAL <= pin_in[0];
            BANK0_PULL_EN  <= ~hold_reg[0];
            BANK0_PULL_UP  <= pull_reg[0];
            BANK1_PIN_O    <= out_reg[1];
            BANK1_PIN_OE   <= ~dir_reg[1];
            BANK1_HOLD_EN  <= hold_reg[1] & dir_reg[1];
            BANK1_HOLD_VAL <= pin_in[1];
            BANK1_PULL_EN  <= ~hold_reg[1];
            BANK1_PULL_UP  <= pull_reg[1];
        end
    end

endmodule : gex_top
`default_nettype wire

// ===== i2c_gpio_expander_front_end_bench.sv
// i2c_gpio_expander_front_end_bench.sv: self-checking bench for gex_top.
// assumes: gex_ctl plays the controller; pads driven by the bench.
`timescale 1ns/1ps
`default_nettype none
module i2c_gpio_expander_front_end_bench;
    localparam logic [6:0] DEV = 7'h20;
    logic       clk = 1'b0;
    logic       nrst = 1'b0;
    logic [7:0] pin0 = 8'h3c;
    logic [7:0] pin1 = 8'hc3;
    logic       scl, sda_low, sda_o, sda_oe, int_oe, ok;
    logic [7:0] o0, oe0, he0, pe0, pu0, o1, oe1, hv0;
    int         mismatches = 0;
    int         n_tests = 0;
    int         cyc = 0;
    wire logic  sda = !(sda_oe && !sda_o) && !sda_low;
    gex_top #(.FIXED_ADDR(DEV)) u_dut (.CLK_SYS(clk), .NRST(nrst),
        .SCL(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe),
        .ADDR_SELECT_PIN_0(1'b0), .ADDR_SELECT_PIN_1(1'b0),
        .ADDR_SELECT_PIN_2(1'b0), .ADDR_SELECT_PIN_3(1'b0),
        .BANK0_PIN_I(pin0), .BANK0_PIN_O(o0), .BANK0_PIN_OE(oe0),
        .BANK0_HOLD_EN(he0), .BANK0_HOLD_VAL(hv0), .BANK0_PULL_EN(pe0),
        .BANK0_PULL_UP(pu0), .BANK1_PIN_I(pin1), .BANK1_PIN_O(o1),
        .BANK1_PIN_OE(oe1), .BANK1_HOLD_EN(), .BANK1_HOLD_VAL(),
        .BANK1_PULL_EN(), .BANK1_PULL_UP(), .INT_O(), .INT_OE(int_oe));
    gex_ctl u_ctl (.clk(clk), .scl(scl), .sda_low(sda_low), .sda(sda));
    always #5 clk = ~clk;
    // a hung transfer counts as a mismatch
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            mismatches++;
            report_and_stop();
        end
    end
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string nm, input logic [7:0] s, e);
        n_tests++;
        if (s !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // write transfer; data is only sent once address and command are acked
    task automatic wr(input logic [6:0] a, input logic [7:0] c,
                      input logic [7:0] d[$], input logic ea);
        u_ctl.start();
        u_ctl.tx({a, 1'b0}, ok);
        if (ok) u_ctl.tx(c, ok);
        foreach (d[i]) if (ok) u_ctl.tx(d[i], ok);
        u_ctl.stop();
        chk("ack", {7'h00, ok}, {7'h00, ea});
    endtask : wr
    // optional command write, repeated start, reads; x skips a byte
    task automatic rd(input int c, input logic [7:0] e[$]);
        logic [7:0] b;
        u_ctl.start();
        if (c >= 0) begin
            u_ctl.tx({DEV, 1'b0}, ok);
            u_ctl.tx(c[7:0], ok);
            u_ctl.start();
        end
        u_ctl.tx({DEV, 1'b1}, ok);
        foreach (e[i]) begin
            u_ctl.rx(b, i < e.size() - 1);
            if (!$isunknown(e[i])) chk("rdata", b, e[i]);
        end
        u_ctl.stop();
    endtask : rd
    initial begin
        repeat (8) @(posedge clk);
        #1 nrst = 1'b1;
        chk("pull_en", pe0, 8'hff);
        chk("pin_oe", oe0, 8'h00);
        repeat (8) @(posedge clk);
        #1;
        rd(-1, {8'h3c, 8'h3c});
        $display("test reset done");
        wr(DEV, 8'h82, {8'h0f, 8'hf0, 8'h03, 8'h00, 8'h80, 8'h00,
            8'h7e, 8'h00, 8'ha5, 8'h5a}, 1'b1);
        chk("pin_oe", oe0, 8'h81);
        chk("pin_o", o0, 8'ha5);
        chk("hold_en", he0, 8'h02);
        chk("hold_val", hv0, 8'h3c);
        chk("pull_en", pe0, 8'hfc);
        chk("pull_up", pu0, 8'h80);
        chk("pin_oe1", oe1, 8'hff);
        rd(8'h82, {8'h0f, 8'hf0, 8'h03, 8'h00, 8'h80, 8'h00,
            8'h7e, 8'h00, 8'ha5, 8'h5a});
        rd(8'h80, {8'h33, 8'h33});
        $display("test config done");
        wr(DEV, 8'h8e, {8'h11, 8'h22, 8'h33, 8'h44, 8'h55}, 1'b1);
        rd(8'h02, {8'h55});
        wr(DEV, 8'h0a, {8'h11, 8'h22}, 1'b1);
        chk("pin_o", o0, 8'h22);
        chk("pin_o1", o1, 8'h5a);
        wr(DEV, 8'h10, {8'h99}, 1'b0);
        wr(7'h21, 8'h0a, {8'h99}, 1'b0);
        chk("pin_o", o0, 8'h22);
        $display("test pointer done");
        rd(8'h0e, {8'h00});
        wr(DEV, 8'h0c, {8'hfd}, 1'b1);
        chk("int_oe", {7'h00, int_oe}, 8'h00);
        @(posedge clk) #1 pin0[1] = 1'b1;
        repeat (10) @(posedge clk);
        #1;
        chk("int_oe", {7'h00, int_oe}, 8'h01);
        rd(8'h0e, {8'h02});
        chk("int_oe", {7'h00, int_oe}, 8'h00);
        $display("test interrupt done");
        report_and_stop();
    end
endmodule : i2c_gpio_expander_front_end_bench
`default_nettype wire
